// File: core/dac_pd_regs.svh
`ifndef DAC_PD_REGS_SVH
`define DAC_PD_REGS_SVH

`define ADDR_W          4
`define DATA_W          32
`define CODE_W          12
`define MEM_W           17

`define OFS_VCODE       4'h0
`define OFS_VMEM        4'h1
`define OFS_ALLMEM      4'h2
`define OFS_VCFG        4'h3
`define OFS_GC_RESET    4'h4
`define OFS_GC_WAKE     4'h5
`define OFS_STATUS      4'h6

`define RD_VOL          4'h1
`define RD_NV           4'h2

`define F_CODE_LSB      0
`define F_GAIN          12
`define F_PD_LSB        13
`define F_REF_LSB       15

`define ST_IDLE         0
`define ST_POR          1
`define ST_READY        2

`define PD_NORMAL       2'h0
`define PD_BOR          2'h3
`define NV_DEFAULT      17'h00000

`define CLK_PERIOD_NS   20
`define RESET_DELAY_NS  10000
`define PDE_NS          10000
`define EE_WRITE_NS     25000000
`define RESET_DELAY_CYC ((`RESET_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PDE_CYC         ((`PDE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EE_WRITE_CYC    ((`EE_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: core/dac_pd_pkg.sv
package dac_pd_pkg;

    typedef struct packed {
        logic [1:0] ladder_ref_select;
        logic [1:0] powerdown_select;
        logic       gain;
    } cfg_s;

    typedef struct packed {
        cfg_s        cfg;
        logic [11:0] code;
    } mem_s;

    typedef enum logic [1:0] {
        PWR_RUN   = 2'b00,
        PWR_ENTER = 2'b01,
        PWR_DOWN  = 2'b10
    } pwr_e;

endpackage

// File: core/dac_powerdown_reset_memory_ctrl.sv
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "dac_pd_regs.svh"

// Operation
// - Three power-down modes plus normal, chosen by two-bit powerdown_select.
// - Select 00 normal, 01 1k, 10 125k, 11 640k pull-down.
// - Power-down disables circuits, floats the amplifier, detaches ladder.
// - Volatile and nonvolatile contents are kept while powered down.
// - Leaving 00 disables amplifier and applies pull-down only after entry delay.
// - Six commands may update volatile powerdown_select.
// - Command port stays operational in every power-down mode.
// - Exit re-enables circuits, reconnects ladder, drives from volatile state.
// - Select becomes 00 by write of 00, wake-up, reset with NV 00.
// - Power-on copies nonvolatile code and configuration into volatile.
// - Power-on starts reset delay; all commands rejected until it ends.
// - Brown-out forces select 11, clears other volatile bits, rejects commands.
// - General-call reset reloads volatile from nonvolatile without delay timer.
// - Five config bits and code held twice; two volatile status bits.
// - All-memory write loads volatile with the same values as nonvolatile.
// - EEPROM programming starts at the nonvolatile write command itself.
// - eeprom_idle_flag 0 while programming; only reads accepted then.
// - Power-on flag is 1 above trip point, 0 when powered off.
// - Output depends only on volatile code and configuration.
// - Ladder reference 0x supply, 10 pin unbuffered, 11 pin buffered.
// - Gain bit doubles output, forced unity when supply is reference.
module dac_powerdown_reset_memory_ctrl
    import dac_pd_pkg::*;
#(
    parameter int unsigned EE_WRITE_CYCLES = `EE_WRITE_CYC
) (
    input  wire logic                 CLK_I,
    input  wire logic                 RST_I,
    input  wire logic                 SUPPLY_OK_I,
    input  wire logic [`ADDR_W-1:0]   ADDR_I,
    input  wire logic [`DATA_W-1:0]   WDATA_I,
    input  wire logic                 WR_I,
    input  wire logic                 RD_I,
    output logic      [`DATA_W-1:0]   RDATA_O,
    output logic      [`CODE_W-1:0]   CODE_O,
    output logic      [1:0]           LADDER_REF_SEL_O,
    output logic                      GAIN_DOUBLE_O,
    output logic                      LADDER_CONNECT_O,
    output logic                      AMP_EN_O,
    output logic                      BIAS_EN_O,
    output logic      [1:0]           PULLDOWN_SEL_O,
    output logic                      EEPROM_IDLE_O,
    output logic                      POR_FLAG_O,
    output logic                      CMD_READY_O
);

    logic [2:0]  sup_sync;
    logic        supply_ok;
    logic        next_supply;
    logic        por_evt;
    logic        bor_evt;
    logic [9:0]  rst_cnt;
    logic [20:0] ee_cnt;
    logic [9:0]  pd_cnt;
    logic        accept;
    logic        idle;
    logic        wr_ok;
    mem_s        vol;
    mem_s        nv;
    mem_s        wd_mem;
    pwr_e        pwr;

    function automatic logic is_cmd(input logic [`ADDR_W-1:0] a,
                                    input logic [`ADDR_W-1:0] ofs);
        is_cmd = (a == ofs);
    endfunction

    // The supply detector pin passes three stages; a change is taken once the last two agree.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sup_sync <= 3'h0;
        end else begin
            sup_sync <= {sup_sync[1:0], SUPPLY_OK_I};
        end
    end

    always_comb begin
        next_supply = (sup_sync[1] == sup_sync[2]) ? sup_sync[2] : supply_ok;
        por_evt     = next_supply & ~supply_ok;
        bor_evt     = ~next_supply & supply_ok;
        idle        = (ee_cnt == 21'h0);
        accept      = supply_ok & (rst_cnt == 10'h0);
        wr_ok       = WR_I & accept & idle;
        wd_mem      = mem_s'(WDATA_I[`MEM_W-1:0]);
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            supply_ok <= 1'b0;
        end else begin
            supply_ok <= next_supply;
        end
    end

    // Reset delay timer, started only by a power-on event.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rst_cnt <= 10'h0;
        end else if (por_evt) begin
            rst_cnt <= 10'(`RESET_DELAY_CYC);
        end else if (rst_cnt != 10'h0) begin
            rst_cnt <= rst_cnt - 10'h1;
        end
    end

    // EEPROM programming timer, started by the accepted write itself.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ee_cnt <= 21'h0;
        end else if (wr_ok && is_cmd(ADDR_I, `OFS_ALLMEM)) begin
            ee_cnt <= 21'(EE_WRITE_CYCLES);
        end else if (ee_cnt != 21'h0) begin
            ee_cnt <= ee_cnt - 21'h1;
        end
    end

    // Nonvolatile copy, changed only by the all-memory write.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            nv <= mem_s'(`NV_DEFAULT);
        end else if (wr_ok && is_cmd(ADDR_I, `OFS_ALLMEM)) begin
            nv <= wd_mem;
        end
    end

    // Volatile copy and its command updates.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            vol     <= mem_s'(`NV_DEFAULT);
            vol.cfg.powerdown_select <= `PD_BOR;
        end else if (bor_evt) begin
            vol     <= mem_s'(`NV_DEFAULT);
            vol.cfg.powerdown_select <= `PD_BOR;
        end else if (por_evt) begin
            vol <= nv;
        end else if (wr_ok) begin
            case (ADDR_I)
                `OFS_VCODE: begin
                    vol.code <= wd_mem.code;
                    vol.cfg.powerdown_select <= wd_mem.cfg.powerdown_select;
                end
                `OFS_VMEM: begin
                    vol <= wd_mem;
                end
                `OFS_ALLMEM: begin
                    vol <= wd_mem;
                end
                `OFS_VCFG: begin
                    vol.cfg <= wd_mem.cfg;
                end
                `OFS_GC_RESET: begin
                    vol <= nv;
                end
                `OFS_GC_WAKE: begin
                    vol.cfg.powerdown_select <= `PD_NORMAL;
                end
                default: begin
                end
            endcase
        end
    end

    // Power-down sequencing with the entry delay.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            pwr    <= PWR_DOWN;
            pd_cnt <= 10'h0;
        end else begin
            case (pwr)
                PWR_RUN: begin
                    if (vol.cfg.powerdown_select != `PD_NORMAL) begin
                        pwr    <= PWR_ENTER;
                        pd_cnt <= 10'(`PDE_CYC - 1);
                    end
                end
                PWR_ENTER: begin
                    if (vol.cfg.powerdown_select == `PD_NORMAL) begin
                        pwr <= PWR_RUN;
                    end else if (pd_cnt == 10'h0) begin
                        pwr <= PWR_DOWN;
                    end else begin
                        pd_cnt <= pd_cnt - 10'h1;
                    end
                end
                PWR_DOWN: begin
                    if (vol.cfg.powerdown_select == `PD_NORMAL) begin
                        pwr <= PWR_RUN;
                    end
                end
                default: begin
                    pwr <= PWR_RUN;
                end
            endcase
        end
    end

    // Analog controls: code, reference and gain from the volatile copy; enables and pull-down from the power-down state.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            CODE_O           <= 12'h000;
            LADDER_REF_SEL_O <= 2'h0;
            GAIN_DOUBLE_O    <= 1'b0;
            LADDER_CONNECT_O <= 1'b0;
            AMP_EN_O         <= 1'b0;
            BIAS_EN_O        <= 1'b0;
            PULLDOWN_SEL_O   <= `PD_BOR;
        end else begin
            CODE_O           <= vol.code;
            LADDER_REF_SEL_O <= vol.cfg.ladder_ref_select;
            GAIN_DOUBLE_O    <= vol.cfg.gain
                                & vol.cfg.ladder_ref_select[1];
            LADDER_CONNECT_O <= (pwr != PWR_DOWN);
            AMP_EN_O         <= (pwr != PWR_DOWN);
            BIAS_EN_O        <= (pwr != PWR_DOWN);
            PULLDOWN_SEL_O   <= (pwr == PWR_DOWN)
                                ? vol.cfg.powerdown_select
                                : `PD_NORMAL;
        end
    end

    // Status outputs and register reads.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            EEPROM_IDLE_O <= 1'b1;
            POR_FLAG_O    <= 1'b0;
            CMD_READY_O   <= 1'b0;
            RDATA_O       <= 32'h0;
        end else begin
            EEPROM_IDLE_O <= idle;
            POR_FLAG_O    <= supply_ok;
            CMD_READY_O   <= accept;
            RDATA_O       <= 32'h0;
            if (RD_I && accept) begin
                case (ADDR_I)
                    `RD_VOL: begin
                        RDATA_O <= {15'h0, vol};
                    end
                    `RD_NV: begin
                        RDATA_O <= {15'h0, nv};
                    end
                    `OFS_STATUS: begin
                        RDATA_O[`ST_IDLE]  <= idle;
                        RDATA_O[`ST_POR]   <= supply_ok;
                        RDATA_O[`ST_READY] <= accept;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    a_bor_forces_off: assert property (
        bor_evt |=> vol.cfg.powerdown_select == `PD_BOR
            && vol.code == 12'h000 && !accept)
        else $error("Brown-out did not force power-down state.");

    a_por_reload_vol: assert property (
        por_evt |=> vol == $past(nv) && rst_cnt == 10'(`RESET_DELAY_CYC))
        else $error("Power-on did not reload volatile copy.");

    a_delay_rejects: assert property (
        (rst_cnt != 10'h0 && WR_I && !bor_evt) |=> $stable(vol))
        else $error("Command taken during reset delay.");

    a_busy_blocks_wr: assert property (
        (!idle && WR_I && !bor_evt && !por_evt) |=> $stable(vol)
            && $stable(nv) && !EEPROM_IDLE_O)
        else $error("Command taken while EEPROM busy.");

    a_allmem_mirror: assert property (
        (wr_ok && is_cmd(ADDR_I, `OFS_ALLMEM) && !bor_evt)
            |=> vol == nv && !idle ##1 !EEPROM_IDLE_O)
        else $error("All-memory write did not mirror or start programming.");

    a_entry_waits: assert property (
        (pwr == PWR_RUN && vol.cfg.powerdown_select != `PD_NORMAL)
            |=> pwr == PWR_ENTER ##1 AMP_EN_O [*3])
        else $error("Power-down entered before the entry delay.");

    a_down_pulldown: assert property (
        pwr == PWR_DOWN |=> !AMP_EN_O && !LADDER_CONNECT_O
            && PULLDOWN_SEL_O == $past(vol.cfg.powerdown_select))
        else $error("Power-down outputs wrong.");

    a_exit_drives: assert property (
        (pwr == PWR_DOWN && vol.cfg.powerdown_select == `PD_NORMAL)
            |=> ##1 AMP_EN_O && LADDER_CONNECT_O
            && PULLDOWN_SEL_O == `PD_NORMAL)
        else $error("Power-down exit did not restore the output.");

    a_wake_clears_pd: assert property (
        (wr_ok && is_cmd(ADDR_I, `OFS_GC_WAKE) && !bor_evt)
            |=> vol.cfg.powerdown_select == `PD_NORMAL)
        else $error("Wake-up did not clear power-down select.");

    a_gcreset_load: assert property (
        (wr_ok && is_cmd(ADDR_I, `OFS_GC_RESET) && !bor_evt)
            |=> vol == $past(nv) && rst_cnt == 10'h0)
        else $error("General-call reset reload wrong.");

    a_gain_unity: assert property (
        !vol.cfg.ladder_ref_select[1] |=> !GAIN_DOUBLE_O)
        else $error("Double gain with supply reference.");

    a_down_retains: assert property (
        (pwr == PWR_DOWN && !WR_I && !bor_evt && !por_evt)
            |=> $stable(vol) && $stable(nv))
        else $error("Memory changed while powered down.");

    a_code_volatile: assert property (
        1'b1 |=> CODE_O == $past(vol.code)
            && LADDER_REF_SEL_O == $past(vol.cfg.ladder_ref_select))
        else $error("Output controls not taken from volatile copy.");

    a_run_released: assert property (
        pwr != PWR_DOWN |=> AMP_EN_O && LADDER_CONNECT_O && BIAS_EN_O
            && PULLDOWN_SEL_O == `PD_NORMAL)
        else $error("Output not driven outside power-down.");

    a_idle_flag: assert property (
        1'b1 |=> EEPROM_IDLE_O == $past(idle))
        else $error("Idle flag does not follow the programming timer.");

    a_status_read: assert property (
        (RD_I && accept && is_cmd(ADDR_I, `OFS_STATUS))
            |=> RDATA_O[`ST_IDLE] == $past(idle)
            && RDATA_O[`ST_POR] == $past(supply_ok))
        else $error("Status read returned wrong flags.");

    a_read_refused: assert property (
        (RD_I && !accept) |=> RDATA_O == 32'h0)
        else $error("Read answered while commands are refused.");

    a_nv_only_allmem: assert property (
        !(wr_ok && is_cmd(ADDR_I, `OFS_ALLMEM)) |=> $stable(nv))
        else $error("Nonvolatile copy changed without all-memory write.");

    a_entry_holds: assert property (
        (pwr == PWR_ENTER && pd_cnt != 10'h0
            && vol.cfg.powerdown_select != `PD_NORMAL)
            |=> pwr == PWR_ENTER)
        else $error("Power-down entry delay cut short.");

endmodule // dac_powerdown_reset_memory_ctrl

// File: tb/bus_master.sv
`timescale 1ns/100ps
`include "dac_pd_regs.svh"

// Register bus master standing in for the serial host.
module bus_master (
    input  wire logic               clk_i,
    input  wire logic [`DATA_W-1:0] rdata_i,
    output logic      [`ADDR_W-1:0] addr_o,
    output logic      [`DATA_W-1:0] wdata_o,
    output logic                    wr_o,
    output logic                    rd_o
);
    initial begin
        addr_o = '0;
        wdata_o = '0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // Released lines show the inverse of their last value.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        q = rdata_i;
    endtask

    // Polls the status word until the programming cycle is over.
    task automatic wait_idle();
        logic [31:0] s = '0;
        for (int i = 0; i < 200 && s[0] !== 1'b1; i++) begin
            rd(`OFS_STATUS, s);
        end
    endtask
endmodule // bus_master

// File: tb/testbench.sv
`timescale 1ns/100ps
`include "dac_pd_regs.svh"
`define CHK(g, e) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
end

module testbench
    import dac_pd_pkg::*;
;
    logic               clk;
    logic               rst;
    logic               supply_ok;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic [`DATA_W-1:0] rdata;
    logic               wr;
    logic               rd;
    logic [11:0]        code;
    logic [1:0]         ref_sel;
    logic [1:0]         pd_sel;
    logic               gain_dbl;
    logic               ladder_con;
    logic               amp_en;
    logic               bias_en;
    logic               ee_idle;
    logic               por_flag;
    logic               cmd_ready;
    logic [16:0]        vol;
    logic [16:0]        nv;
    logic [31:0]        seed;
    logic [31:0]        q;
    int                 errors;
    int                 n_checks;
    int                 cyc;

    dac_powerdown_reset_memory_ctrl #(
        .EE_WRITE_CYCLES(20)
    ) dac_powerdown_reset_memory_ctrl_inst (
        .CLK_I(clk), .RST_I(rst), .SUPPLY_OK_I(supply_ok), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .CODE_O(code), .LADDER_REF_SEL_O(ref_sel), .GAIN_DOUBLE_O(gain_dbl),
        .LADDER_CONNECT_O(ladder_con), .AMP_EN_O(amp_en),
        .BIAS_EN_O(bias_en), .PULLDOWN_SEL_O(pd_sel),
        .EEPROM_IDLE_O(ee_idle), .POR_FLAG_O(por_flag),
        .CMD_READY_O(cmd_ready)
    );

    bus_master bus_master_inst (
        .clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd)
    );

    always #(`CLK_PERIOD_NS / 2) clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [31:0] rnd(input logic [1:0] pd);
        seed = lfsr(seed);
        return {15'h0, seed[16:15], pd, seed[12:0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Writes a command and, when it should be taken, updates the model.
    task automatic mw(input logic [3:0] a, input logic [31:0] d,
                      input bit take);
        bus_master_inst.wr(a, d);
        tick(2);
        if (take) begin
            case (a)
                `OFS_VCODE: vol = {vol[16:15], d[14:13], vol[12], d[11:0]};
                `OFS_VMEM: vol = d[16:0];
                `OFS_ALLMEM: begin
                    vol = d[16:0];
                    nv = d[16:0];
                end
                `OFS_VCFG: vol[16:12] = d[16:12];
                `OFS_GC_RESET: vol = nv;
                `OFS_GC_WAKE: vol[14:13] = 2'h0;
                default: ;
            endcase
        end
    endtask

    task automatic chk_vol();
        bus_master_inst.rd(`RD_VOL, q);
        `CHK(q, {15'h0, vol})
        bus_master_inst.rd(`RD_NV, q);
        `CHK(q, {15'h0, nv})
        `CHK(code, vol[11:0])
        `CHK(ref_sel, vol[16:15])
        `CHK(gain_dbl, vol[12] & vol[16])
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            close_out();
        end
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        supply_ok = 1'b0;
        errors = 0;
        n_checks = 0;
        cyc = 0;
        seed = 32'h06D4;
        vol = 17'h06000;
        nv = 17'h00000;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        `CHK({amp_en, pd_sel}, 3'h3)
        @(posedge clk) supply_ok <= 1'b1;
        tick(20);
        mw(`OFS_VCODE, 32'h0ABC, 1'b0);
        `CHK(cmd_ready, 1'b0)
        for (int i = 0; i < 700 && cmd_ready !== 1'b1; i++) tick(1);
        `CHK(cmd_ready, 1'b1)
        vol = nv;
        chk_vol();
        bus_master_inst.rd(`OFS_STATUS, q);
        `CHK(q[2:0], 3'h7)
        $display("test startup done");
        for (int i = 0; i < 8; i++) begin
            q = rnd(2'h0);
            q[16:15] = i[1:0];
            q[12] = i[2];
            mw(i[0] ? `OFS_VCODE : `OFS_VMEM, q, 1'b1);
            chk_vol();
        end
        $display("test volatile writes done");
        for (int m = 1; m < 4; m++) begin
            mw(`OFS_VCFG, rnd(m[1:0]), 1'b1);
            tick(400);
            `CHK(amp_en, 1'b1)
            for (int i = 0; i < 300 && amp_en !== 1'b0; i++) tick(1);
            `CHK(pd_sel, m[1:0])
            `CHK({ladder_con, bias_en}, 2'h0)
            mw(`OFS_VCODE, rnd(m[1:0]), 1'b1);
            chk_vol();
            case (m)
                1: mw(`OFS_GC_WAKE, 32'h0, 1'b1);
                2: mw(`OFS_VCODE, rnd(2'h0), 1'b1);
                default: mw(`OFS_VMEM, rnd(2'h0), 1'b1);
            endcase
            tick(3);
            `CHK({amp_en, ladder_con, bias_en}, 3'h7)
            `CHK(pd_sel, 2'h0)
            chk_vol();
        end
        $display("test power-down modes done");
        mw(`OFS_ALLMEM, rnd(2'h0), 1'b1);
        tick(1);
        `CHK(ee_idle, 1'b0)
        mw(`OFS_VCODE, rnd(2'h0), 1'b0);
        bus_master_inst.rd(`OFS_STATUS, q);
        `CHK(q[0], 1'b0)
        bus_master_inst.wait_idle();
        chk_vol();
        $display("test nonvolatile write done");
        mw(`OFS_VMEM, rnd(2'h0), 1'b1);
        mw(`OFS_GC_RESET, 32'h0, 1'b1);
        `CHK(cmd_ready, 1'b1)
        chk_vol();
        mw(`OFS_ALLMEM, rnd(2'h2), 1'b1);
        bus_master_inst.wait_idle();
        mw(`OFS_VMEM, rnd(2'h0), 1'b1);
        mw(`OFS_GC_RESET, 32'h0, 1'b1);
        for (int i = 0; i < 700 && amp_en !== 1'b0; i++) tick(1);
        `CHK({amp_en, pd_sel}, 3'h2)
        $display("test general call done");
        @(posedge clk) supply_ok <= 1'b0;
        tick(10);
        mw(`OFS_VCODE, rnd(2'h0), 1'b0);
        bus_master_inst.rd(`RD_VOL, q);
        `CHK(q, 32'h0)
        `CHK(code, 12'h000)
        `CHK(por_flag, 1'b0)
        tick(3);
        `CHK(pd_sel, 2'h3)
        @(posedge clk) supply_ok <= 1'b1;
        vol = nv;
        tick(20);
        for (int i = 0; i < 700 && cmd_ready !== 1'b1; i++) tick(1);
        chk_vol();
        `CHK(pd_sel, 2'h2)
        $display("test brown-out done");
        close_out();
    end
endmodule // testbench
